// ==== hw/scrw_pkg.sv ====
package scrw_pkg;

  // system states, gray along standby->operating->idle
  typedef enum logic [1:0] {
    SCRW_STANDBY   = 2'h0,
    SCRW_OPERATING = 2'h1,
    SCRW_IDLE      = 2'h3
  } scrw_state_e;

  // clock rate and times
  localparam int unsigned CLK_HZ         = 10000000;
  localparam int unsigned WAKE_MIN_US    = 125;
  localparam int unsigned WAKE_BLIND_S   = 2;
  // longest filter delay kept below the wake time, so detection is certain
  localparam int unsigned WAKE_CYCLES    = (WAKE_MIN_US * (CLK_HZ / 1000000)) / 2;
  localparam int unsigned WAKE_BLIND_CYC = WAKE_BLIND_S * CLK_HZ;
  localparam int unsigned FILT_SAMPLES   = 4;
  localparam int unsigned FILT_W         = 12;
  localparam int unsigned BLIND_W        = 25;

  // strap widths
  localparam int unsigned TEST_W = 2;
  localparam int unsigned EXP_W  = 3;
  localparam int unsigned DRV_W  = 2;
  localparam int unsigned DISP_W = 4;

  // test mode code: user reset low at release with a test strap set
  localparam logic [TEST_W-1:0] TEST_NONE = 2'h0;

  // straps caught at power-on reset release
  typedef struct packed {
    logic              user_reset_n;
    logic [TEST_W-1:0] test;
    logic [EXP_W-1:0]  expansion_strap;
    logic [DRV_W-1:0]  drive;
    logic [DISP_W-1:0] display_data_strap;
  } scrw_strap_s;

endpackage : scrw_pkg

// ==== hw/scrw_deglitch.sv ====
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser then stability filter
module scrw_deglitch #(
  parameter int unsigned        STABLE = 4,
  parameter logic               INIT   = 1'b1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pin and filtered level
  input  wire logic pin,
  output logic      level
);

  typedef struct packed {
    logic                                 s1;
    logic                                 s2;
    logic [scrw_pkg::FILT_W-1:0]          cnt;
    logic                                 out;
  } scrw_dg_s;

  localparam logic [scrw_pkg::FILT_W-1:0] LAST = scrw_pkg::FILT_W'(STABLE - 1);

  scrw_dg_s st_q;  // all state
  scrw_dg_s st_d;  // next state

  // count samples that differ from output; any agreement restarts
  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    if (st_q.s2 == st_q.out) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == LAST) begin
      st_d.out = st_q.s2;
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '{s1: INIT, s2: INIT, cnt: '0, out: INIT};
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.out;

  AST_FILT_HOLD: assert property (@(posedge clk) disable iff (rst)
    st_q.out != $past(st_q.out) |-> $past(st_q.s2) == st_q.out)
    else $error("filter changed without matching sample");

endmodule : scrw_deglitch
`default_nettype wire

// ==== hw/scrw_strap.sv ====
`timescale 1ns/100ps
`default_nettype none
// captures straps once, on first clock after reset release
module scrw_strap (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // live straps and held copy
  input  wire scrw_pkg::scrw_strap_s pins,
  output scrw_pkg::scrw_strap_s     held,
  output logic                      done
);

  typedef struct packed {
    scrw_pkg::scrw_strap_s v;
    logic                  done;
  } scrw_sp_s;

  scrw_sp_s st_q;  // all state
  scrw_sp_s st_d;  // next state

  // clocked capture: async reset may only load constants
  always_comb begin
    st_d = st_q;
    if (!st_q.done) begin
      st_d.v    = pins;
      st_d.done = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign held = st_q.v;
  assign done = st_q.done;

  AST_STRAP_FROZEN: assert property (@(posedge clk) disable iff (rst)
    $past(st_q.done) |-> st_q.v == $past(st_q.v))
    else $error("strap copy changed after capture");

endmodule : scrw_strap
`default_nettype wire

// ==== hw/scrw_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// state control: resets, straps, run indicator, wake qualification
module scrw_top #(
  parameter int unsigned WAKE_BLIND = scrw_pkg::WAKE_BLIND_CYC, // long, shorten in sim
  parameter int unsigned WAKE_HOLD  = scrw_pkg::WAKE_CYCLES
) (
  // clock and power-on reset (rst is the inverted power_on_reset_n)
  input  wire logic                  clk,
  input  wire logic                  rst,
  // filtered control inputs
  input  wire logic                  user_reset_n,
  input  wire logic                  battery_change_n,
  input  wire logic                  power_fail_n,
  input  wire logic                  battery_good,
  input  wire logic                  wake_req,
  // software requests
  input  wire logic                  sw_standby,
  input  wire logic                  sw_idle,
  input  wire logic                  sw_resume,
  // strap pins
  input  wire scrw_pkg::scrw_strap_s strap_pins,
  // status outputs
  output logic                       run,
  output logic                       sys_reset,
  output logic                       rtc_reset,
  output logic                       test_mode,
  output logic [scrw_pkg::TEST_W-1:0] test_sel,
  output logic                       no_battery,
  output logic                       fast_interrupt,
  output scrw_pkg::scrw_strap_s      straps
);

  // all state of the sequencer
  typedef struct packed {
    scrw_pkg::scrw_state_e            state;
    logic [scrw_pkg::BLIND_W-1:0]     blind;
    logic                             blind_done;
    logic [scrw_pkg::FILT_W-1:0]      wake_cnt;
    logic                             bat_prev;
    logic                             run;
    logic                             sys_reset;
    logic                             rtc_reset;
    logic                             test_mode;
    logic [scrw_pkg::TEST_W-1:0]      test_sel;
    logic                             no_battery;
    logic                             fast_int;
    scrw_pkg::scrw_strap_s            straps;
  } scrw_top_s;

  scrw_top_s st_q;  // registered state
  scrw_top_s st_d;  // next state

  // filtered levels
  logic ur_f;     // user reset, low active
  logic bc_f;     // battery change, low active
  logic pf_f;     // power fail, low active
  logic bg_f;     // battery good
  logic wk_s;     // wake, synchronised and stability filtered
  scrw_pkg::scrw_strap_s held;  // captured straps
  logic                  held_ok; // capture complete

  localparam logic [scrw_pkg::BLIND_W-1:0] BLIND_LAST =
    scrw_pkg::BLIND_W'(WAKE_BLIND - 1);
  localparam logic [scrw_pkg::FILT_W-1:0]  WAKE_LAST  =
    scrw_pkg::FILT_W'(WAKE_HOLD - 1);

  // one filter per input; wake gets a short one, its long hold is counted here
  // user reset filter starts released, so no reset pulse right after release
  scrw_deglitch #(.STABLE(scrw_pkg::FILT_SAMPLES), .INIT(1'b1)) u_ur (
    .clk  (clk),
    .rst  (rst),
    .pin  (user_reset_n),
    .level(ur_f)
  );
  // battery change filter starts at the good level
  scrw_deglitch #(.STABLE(scrw_pkg::FILT_SAMPLES), .INIT(1'b1)) u_bc (
    .clk  (clk),
    .rst  (rst),
    .pin  (battery_change_n),
    .level(bc_f)
  );
  // power fail filter starts inactive
  scrw_deglitch #(.STABLE(scrw_pkg::FILT_SAMPLES), .INIT(1'b1)) u_pf (
    .clk  (clk),
    .rst  (rst),
    .pin  (power_fail_n),
    .level(pf_f)
  );
  // battery good starts high, matching bat_prev, so no false fall after reset
  scrw_deglitch #(.STABLE(scrw_pkg::FILT_SAMPLES), .INIT(1'b1)) u_bg (
    .clk  (clk),
    .rst  (rst),
    .pin  (battery_good),
    .level(bg_f)
  );
  // wake idles low, so reset never fakes a wake
  scrw_deglitch #(.STABLE(scrw_pkg::FILT_SAMPLES), .INIT(1'b0)) u_wk (
    .clk  (clk),
    .rst  (rst),
    .pin  (wake_req),
    .level(wk_s)
  );

  // strap capture right after power-on reset release
  scrw_strap u_strap (
    .clk (clk),
    .rst (rst),
    .pins(strap_pins),
    .held(held),
    .done(held_ok)
  );

  // wake is accepted only after blind window and only in standby
  function automatic logic wake_ok(input scrw_top_s s, input logic w);
    return s.blind_done && s.state == scrw_pkg::SCRW_STANDBY && w &&
           s.wake_cnt == WAKE_LAST;
  endfunction : wake_ok

  // sequencer next state
  always_comb begin
    st_d          = st_q;
    st_d.bat_prev = bg_f;
    st_d.fast_int = 1'b0;
    // blind window after reset release
    if (!st_q.blind_done) begin
      if (st_q.blind == BLIND_LAST) begin
        st_d.blind_done = 1'b1;
      end else begin
        st_d.blind = st_q.blind + 1'b1;
      end
    end
    // wake hold counter, only meaningful in standby
    if (wk_s && st_q.state == scrw_pkg::SCRW_STANDBY) begin
      if (st_q.wake_cnt != WAKE_LAST) begin
        st_d.wake_cnt = st_q.wake_cnt + 1'b1;
      end
    end else begin
      st_d.wake_cnt = '0;
    end
    // falling edge on battery good raises a one-cycle interrupt
    if (st_q.bat_prev && !bg_f) begin
      st_d.fast_int = 1'b1;
    end
    // state transitions; power fail has priority
    case (st_q.state)
      scrw_pkg::SCRW_STANDBY: begin
        if (pf_f && bg_f && wake_ok(st_q, wk_s)) begin
          st_d.state = scrw_pkg::SCRW_OPERATING;
        end
      end
      scrw_pkg::SCRW_OPERATING: begin
        if (!pf_f || sw_standby) begin
          st_d.state = scrw_pkg::SCRW_STANDBY;
        end else if (sw_idle) begin
          st_d.state = scrw_pkg::SCRW_IDLE;
        end
      end
      scrw_pkg::SCRW_IDLE: begin
        if (!pf_f || sw_standby) begin
          st_d.state = scrw_pkg::SCRW_STANDBY;
        end else if (sw_resume) begin
          st_d.state = scrw_pkg::SCRW_OPERATING;
        end
      end
      default: begin
        st_d.state = scrw_pkg::SCRW_STANDBY;
      end
    endcase
    // user reset: system back to standby, clock domain untouched
    if (!ur_f) begin
      st_d.state = scrw_pkg::SCRW_STANDBY;
    end
    st_d.sys_reset = !ur_f;
    st_d.rtc_reset = 1'b0;
    st_d.run = (st_d.state != scrw_pkg::SCRW_STANDBY);
    st_d.no_battery = !bc_f;
    // test mode decision from captured straps
    if (held_ok) begin
      st_d.straps    = held;
      st_d.test_sel  = held.test;
      st_d.test_mode = !held.user_reset_n &&
                       held.test != scrw_pkg::TEST_NONE;
    end
  end

  // reset acts asynchronously and unfiltered on everything, rtc reset held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q           <= '0;
      st_q.state     <= scrw_pkg::SCRW_STANDBY;
      st_q.sys_reset <= 1'b1;
      st_q.rtc_reset <= 1'b1;
      st_q.bat_prev  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign run            = st_q.run;
  assign sys_reset      = st_q.sys_reset;
  assign rtc_reset      = st_q.rtc_reset;
  assign test_mode      = st_q.test_mode;
  assign test_sel       = st_q.test_sel;
  assign no_battery     = st_q.no_battery;
  assign fast_interrupt = st_q.fast_int;
  assign straps         = st_q.straps;

  AST_RUN_STATE: assert property (@(posedge clk) disable iff (rst)
    run == (st_q.state != scrw_pkg::SCRW_STANDBY))
    else $error("run disagrees with state");

  AST_WAKE_ONLY_STANDBY: assert property (@(posedge clk) disable iff (rst)
    $past(st_q.state) == scrw_pkg::SCRW_STANDBY &&
    st_q.state == scrw_pkg::SCRW_OPERATING |-> $past(st_q.blind_done))
    else $error("wake taken during blind window");

  AST_PF_STANDBY: assert property (@(posedge clk) disable iff (rst)
    !pf_f && st_q.state != scrw_pkg::SCRW_STANDBY |=>
    st_q.state == scrw_pkg::SCRW_STANDBY)
    else $error("power fail did not force standby");

  AST_UR_RESET: assert property (@(posedge clk) disable iff (rst)
    !ur_f |=> sys_reset && !rtc_reset && !run)
    else $error("user reset wrong effect");

  AST_BAT_FALL_INT: assert property (@(posedge clk) disable iff (rst)
    $fell(bg_f) |=> fast_interrupt)
    else $error("battery fall gave no interrupt");

  AST_BAT_BLOCK: assert property (@(posedge clk) disable iff (rst)
    st_q.state == scrw_pkg::SCRW_STANDBY && !bg_f |=>
    st_q.state == scrw_pkg::SCRW_STANDBY)
    else $error("start with battery low");

  AST_NO_BAT: assert property (@(posedge clk) disable iff (rst)
    !bc_f |=> no_battery)
    else $error("battery change not reported");

  AST_TEST_MODE: assert property (@(posedge clk) disable iff (rst)
    held_ok |=> test_mode == (!held.user_reset_n &&
                              held.test != scrw_pkg::TEST_NONE))
    else $error("test mode decode wrong");

  // clock state reset is released one edge after power-on reset and stays so
  AST_RTC_ONLY_POR: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> !rtc_reset)
    else $error("clock state reset outside power-on reset");

  // wake counter is cleared whenever the system is not in standby
  AST_WAKE_CNT_IDLE: assert property (@(posedge clk) disable iff (rst)
    $past(st_q.state) != scrw_pkg::SCRW_STANDBY |-> st_q.wake_cnt == '0)
    else $error("wake counted outside standby");

  // leaving standby needs the full filtered wake hold
  AST_WAKE_HOLD: assert property (@(posedge clk) disable iff (rst)
    $past(st_q.state) == scrw_pkg::SCRW_STANDBY &&
    st_q.state == scrw_pkg::SCRW_OPERATING |->
    $past(st_q.wake_cnt) == WAKE_LAST && $past(wk_s))
    else $error("wake taken before full hold");

  // without a qualified wake standby is never left
  AST_STANDBY_STAYS: assert property (@(posedge clk) disable iff (rst)
    st_q.state == scrw_pkg::SCRW_STANDBY && !wake_ok(st_q, wk_s) |=>
    st_q.state == scrw_pkg::SCRW_STANDBY)
    else $error("standby left without wake");

  // interrupt is a single-cycle pulse
  AST_INT_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)
    fast_interrupt |=> !fast_interrupt)
    else $error("interrupt longer than one cycle");

  // during the blind window the system stays in standby
  AST_BLIND_STANDBY: assert property (@(posedge clk) disable iff (rst)
    !st_q.blind_done |-> st_q.state == scrw_pkg::SCRW_STANDBY)
    else $error("left standby during blind window");

  // battery report clears when the filtered input is high again
  AST_BAT_CLEAR: assert property (@(posedge clk) disable iff (rst)
    bc_f |=> !no_battery)
    else $error("battery report stuck");

  // system reset follows the filtered user reset release
  AST_UR_RELEASE: assert property (@(posedge clk) disable iff (rst)
    ur_f |=> !sys_reset)
    else $error("system reset without user reset");

  // power fail holds standby even if a wake arrives
  AST_PF_HOLDS: assert property (@(posedge clk) disable iff (rst)
    st_q.state == scrw_pkg::SCRW_STANDBY && !pf_f |=>
    st_q.state == scrw_pkg::SCRW_STANDBY)
    else $error("start during power fail");

  // strap output mirrors the captured copy one edge later
  AST_STRAPS_OUT: assert property (@(posedge clk) disable iff (rst)
    held_ok |=> straps == $past(held))
    else $error("strap output differs from capture");

  // test select mirrors the captured test straps
  AST_TEST_SEL: assert property (@(posedge clk) disable iff (rst)
    held_ok |=> test_sel == $past(held.test))
    else $error("test select differs from capture");

  // state register never holds the unused code
  AST_STATE_LEGAL: assert property (@(posedge clk) disable iff (rst)
    st_q.state == scrw_pkg::SCRW_STANDBY || st_q.state == scrw_pkg::SCRW_OPERATING ||
    st_q.state == scrw_pkg::SCRW_IDLE)
    else $error("illegal state code");

endmodule : scrw_top
`default_nettype wire

// ==== verification/scrw_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
// far side: supervisor owns power-on reset, wake logic owns wake request
module scrw_partner (
  // clock from the bench
  input  wire logic clk,
  // driven lines
  output logic      rst,
  output logic      wake_req
);
  // reset up from time zero, as during a supply ramp
  initial begin
    rst      = 1'b1;
    wake_req = 1'b0;
  end

  // release after a hold; a short stand-in for the settle time
  task automatic release_after(input int cyc);
    repeat (cyc) @(posedge clk);
    rst <= 1'b0;
  endtask : release_after

  // pulse launched between edges, never shorter than half a clock
  task automatic pulse(input int cyc);
    @(negedge clk);
    rst <= 1'b1;
    release_after((cyc < 1) ? 1 : cyc);
  endtask : pulse

  // wake high for a span; the caller decides when that may start
  task automatic wake(input int cyc);
    @(posedge clk);
    wake_req <= 1'b1;
    repeat (cyc) @(posedge clk);
    wake_req <= 1'b0;
  endtask : wake
endmodule : scrw_partner
`default_nettype wire

// ==== verification/state_control_reset_wake_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
// compare, count, report a miss at once
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin mismatches++; $display("BAD %0t %s", $time, m); end end
module state_control_reset_wake_tb;
  localparam int BLIND = 50; // short blind window keeps the run small
  localparam int HOLD  = 8;  // short wake hold
  // stimulus and observed lines
  logic                  clk, user_reset_n, battery_change_n, power_fail_n, battery_good;
  logic                  sw_standby, sw_idle, sw_resume, exp_run;
  scrw_pkg::scrw_strap_s strap_pins;
  wire logic             rst, wake_req, run, sys_reset, rtc_reset, test_mode;
  wire logic             no_battery, fast_interrupt;
  wire logic [scrw_pkg::TEST_W-1:0] test_sel;
  wire scrw_pkg::scrw_strap_s straps;
  // model state and tallies
  scrw_pkg::scrw_strap_s exp_q[$];
  logic [15:0]           lfsr = 16'h1140;
  int                    mismatches = 0;
  int                    n_compared = 0;

  scrw_partner partner_u (.clk(clk), .rst(rst), .wake_req(wake_req));

  scrw_top #(.WAKE_BLIND(BLIND), .WAKE_HOLD(HOLD)) dut_u (
    .clk(clk), .rst(rst), .user_reset_n(user_reset_n), .battery_change_n(battery_change_n),
    .power_fail_n(power_fail_n), .battery_good(battery_good), .wake_req(wake_req),
    .sw_standby(sw_standby), .sw_idle(sw_idle), .sw_resume(sw_resume),
    .strap_pins(strap_pins), .run(run), .sys_reset(sys_reset), .rtc_reset(rtc_reset),
    .test_mode(test_mode), .test_sel(test_sel), .no_battery(no_battery),
    .fast_interrupt(fast_interrupt), .straps(straps));

  // galois shift for strap values
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {1'b0, v[15:1]} ^ (v[0] ? 16'hb400 : 16'h0000);
  endfunction : lfsr_next

  // one observed output picked by number
  function automatic logic pick(input int sel);
    case (sel)
      0: return run;
      1: return sys_reset;
      2: return no_battery;
      default: return fast_interrupt;
    endcase
  endfunction : pick

  // bounded wait, sampled away from the launching edge
  task automatic wait_for(input int sel, input logic v, input int lim);
    repeat (lim) begin
      @(negedge clk);
      if (pick(sel) === v) break;
    end
  endtask : wait_for

  // wake of twice the hold, then the model expects running
  task automatic wake_up();
    partner_u.wake(2 * HOLD);
    wait_for(0, 1'b1, 2 * HOLD);
    exp_run = 1'b1;
  endtask : wake_up

  // single end point for verdict
  task automatic wrap_up();
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // hang guard, well beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  // main sequence
  initial begin : main
    scrw_pkg::scrw_strap_s s;
    logic                  tm;
    {user_reset_n, battery_change_n, power_fail_n, battery_good} = 4'hf;
    {sw_standby, sw_idle, sw_resume} = 3'h0;
    strap_pins = scrw_pkg::scrw_strap_s'(12'h000);
    exp_run = 1'b0;
    @(negedge clk);
    `CHK(run, 1'b0, "run in reset")
    `CHK({sys_reset, rtc_reset}, 2'h3, "resets in reset")
    // four reset cycles, random straps, user reset low on odd ones
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      s = scrw_pkg::scrw_strap_s'(lfsr[11:0]);
      lfsr = lfsr_next(lfsr);
      s.user_reset_n = ~i[0];
      strap_pins <= s;
      user_reset_n <= s.user_reset_n;
      exp_q.push_back(s);
      if (i == 0) partner_u.release_after(3);
      else partner_u.pulse(i);
      repeat (3) @(posedge clk);
      // pins move afterwards; the held copy must not
      strap_pins <= scrw_pkg::scrw_strap_s'(~s);
      user_reset_n <= 1'b1;
      @(negedge clk);
      s = exp_q.pop_front();
      tm = !s.user_reset_n && (s.test != scrw_pkg::TEST_NONE);
      `CHK(straps, s, "straps held")
      `CHK(test_mode, tm, "test decision")
      `CHK(test_sel, s.test, "test select")
      `CHK(rtc_reset, 1'b0, "clock reset after release")
    end
    wait_for(1, 1'b0, 12);
    `CHK(sys_reset, 1'b0, "user reset released")
    // wake inside the blind window is dropped
    partner_u.wake(20);
    repeat (10) @(negedge clk);
    `CHK(run, 1'b0, "wake while blind")
    repeat (30) @(posedge clk);
    wake_up();
    `CHK(run, exp_run, "wake from standby")
    // idle keeps run high and ignores wake
    @(posedge clk) sw_idle <= 1'b1;
    @(posedge clk) sw_idle <= 1'b0;
    partner_u.wake(2 * HOLD);
    repeat (10) @(negedge clk);
    `CHK(run, 1'b1, "run in idle")
    @(posedge clk) sw_resume <= 1'b1;
    @(posedge clk) sw_resume <= 1'b0;
    @(posedge clk) sw_standby <= 1'b1;
    @(posedge clk) sw_standby <= 1'b0;
    wait_for(0, 1'b0, 4);
    `CHK(run, 1'b0, "software standby")
    wake_up();
    `CHK(run, exp_run, "wake after software standby")
    // power fail drops to standby
    @(posedge clk) power_fail_n <= 1'b0;
    wait_for(0, 1'b0, 12);
    `CHK(run, 1'b0, "power fail")
    @(posedge clk) power_fail_n <= 1'b1;
    @(posedge clk) battery_good <= 1'b0;
    wait_for(3, 1'b1, 12);
    `CHK(fast_interrupt, 1'b1, "interrupt on battery fall")
    @(negedge clk);
    `CHK(fast_interrupt, 1'b0, "interrupt one cycle")
    partner_u.wake(2 * HOLD);
    repeat (10) @(negedge clk);
    `CHK(run, 1'b0, "start blocked by low battery")
    @(posedge clk) battery_good <= 1'b1;
    // short glitch filtered out, long low reported
    @(posedge clk) battery_change_n <= 1'b0;
    repeat (2) @(posedge clk);
    battery_change_n <= 1'b1;
    repeat (10) @(negedge clk);
    `CHK(no_battery, 1'b0, "glitch ignored")
    @(posedge clk) battery_change_n <= 1'b0;
    wait_for(2, 1'b1, 12);
    `CHK(no_battery, 1'b1, "battery low")
    @(posedge clk) battery_change_n <= 1'b1;
    wake_up();
    `CHK(run, exp_run, "wake after battery back")
    // power-on reset between edges acts before any clock
    fork
      partner_u.pulse(1);
      begin
        @(negedge clk);
        #10;
        `CHK(run, 1'b0, "unfiltered reset")
        `CHK({sys_reset, rtc_reset}, 2'h3, "full reset")
      end
    join
    // user reset spares the clock state
    @(posedge clk) user_reset_n <= 1'b0;
    wait_for(1, 1'b1, 12);
    `CHK(sys_reset, 1'b1, "user reset")
    `CHK(rtc_reset, 1'b0, "clock kept in user reset")
    @(posedge clk) user_reset_n <= 1'b1;
    wrap_up();
  end
endmodule : state_control_reset_wake_tb
`default_nettype wire
